/* File: rtl/psr_map.vh */
/*
 * Bit positions, reset values and register addresses of the processor
 * status word block.
 * Assumes inclusion by bare name from the design files of the block.
 */
`ifndef PSR_MAP_VH
`define PSR_MAP_VH

// ----------------------------------------------------------------------------
// APB register addresses
// ----------------------------------------------------------------------------
`define PSR_ADDR_STATUS 12'h000
`define PSR_ADDR_ARB_CTRL 12'h004
`define PSR_ADDR_ARB_STATUS 12'h008
`define PSR_ADDR_STACK_TOP 12'h00c

// ----------------------------------------------------------------------------
// Status word fields
// ----------------------------------------------------------------------------
`define PSR_CP_HI 23
`define PSR_CP_LO 22
`define PSR_RND_BIT 21
`define PSR_SAT_BIT 20
`define PSR_CE_BIT 19
`define PSR_SA_BIT 17
`define PSR_FV_BIT 16
`define PSR_LF_BIT 15
`define PSR_DM_BIT 14
`define PSR_SC_BIT 13
`define PSR_SCL_HI 11
`define PSR_SCL_LO 10
`define PSR_IM_HI 9
`define PSR_IM_LO 8
`define PSR_CC_S_BIT 7
`define PSR_CC_L_BIT 6

// ----------------------------------------------------------------------------
// Writable masks and reset values
// ----------------------------------------------------------------------------
`define PSR_EMR_MASK 8'hfb
`define PSR_MR_MASK 8'hef
`define PSR_CCR_MASK 8'hff
`define PSR_PMOVE_MASK 8'hc0
`define PSR_EMR_RESET 8'hc0
`define PSR_MR_RESET 8'h03
`define PSR_CCR_RESET 8'h00

// ----------------------------------------------------------------------------
// Core and DMA priority modes
// ----------------------------------------------------------------------------
`define PSR_CDP_DYNAMIC 2'h0
`define PSR_CDP_CORE_LT 2'h1
`define PSR_CDP_CORE_EQ 2'h2
`define PSR_CDP_CORE_GT 2'h3

`define PSR_STACK_DEPTH 16
`define PSR_STACK_AW 4

`endif

/* File: rtl/psr_byte_reg.v */
/*
 * One 8-bit slice of the status word with a masked write and reset value.
 * Assumes the caller merges all update sources into one write and data.
 */
`timescale 1ns/100ps

module psr_byte_reg #(
    parameter [7:0] RESET_VAL = 8'h00,
    parameter [7:0] WR_MASK = 8'hff
) (
    input wire pclk,
    input wire presetn,
    input wire clk_en,
    input wire wr_en,
    input wire [7:0] wr_data,
    input wire [7:0] wr_bits,
    output wire [7:0] value
);

    reg [7:0] byte_ff;
    wire [7:0] nxt_byte;
    wire [7:0] sel;

    // Only bits both allowed by the slice and chosen by the writer change.
    assign sel = wr_bits & WR_MASK;
    assign nxt_byte = (byte_ff & ~sel) | (wr_data & sel);
    assign value = byte_ff;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            byte_ff <= RESET_VAL;
        end else if (clk_en && wr_en) begin
            byte_ff <= nxt_byte;
        end
    end

endmodule // psr_byte_reg

/* File: rtl/psr_bus_arb.v */
/*
 * External bus arbiter between core program, X, Y requests and DMA.
 * Assumes requests are held until granted and a grant lasts one cycle.
 */
`timescale 1ns/100ps
`include "psr_map.vh"

module psr_bus_arb (
    input wire pclk,
    input wire presetn,
    input wire clk_en,
    input wire [1:0] core_pri,
    input wire [1:0] dma_pri,
    input wire [1:0] cdp_mode,
    input wire bus_free,
    input wire [3:0] req,
    output wire [3:0] grant,
    output wire [1:0] rr_ptr
);

    // Request order is bit 0 program, 1 X data, 2 Y data, 3 DMA.
    reg [1:0] ptr_ff;
    reg [1:0] nxt_ptr;
    reg [3:0] gnt;
    reg core_gt;
    reg core_lt;
    reg [2:0] i;
    reg [1:0] idx;
    reg found;
    wire core_req;

    assign core_req = |req[2:0];
    assign grant = gnt;
    assign rr_ptr = ptr_ff;

    // Static modes fix the outcome whatever the DMA priority, with no clamping at the ends.
    always @* begin
        core_gt = 1'b0;
        core_lt = 1'b0;
        case (cdp_mode)
            `PSR_CDP_DYNAMIC: begin
                core_gt = core_pri > dma_pri;
                core_lt = core_pri < dma_pri;
            end
            `PSR_CDP_CORE_LT: core_lt = 1'b1;
            `PSR_CDP_CORE_EQ: core_gt = 1'b0;
            default: core_gt = 1'b1;
        endcase
    end

    always @* begin
        gnt = 4'h0;
        nxt_ptr = ptr_ff;
        found = 1'b0;
        idx = 2'h0;
        if (bus_free) begin
            if (req[3] && core_req && core_gt) begin
                // Core wins; DMA waits for a later free slot.
                for (i = 3'h0; i < 3'h3; i = i + 3'h1) begin
                    idx = ptr_ff + i[1:0];
                    if (!found && idx != 2'h3 && req[idx]) begin
                        found = 1'b1;
                        gnt[idx] = 1'b1;
                        nxt_ptr = idx + 2'h1;
                    end
                end
                if (!found) begin
                    for (i = 3'h0; i < 3'h3; i = i + 3'h1) begin
                        if (!found && req[i[1:0]]) begin
                            found = 1'b1;
                            gnt[i[1:0]] = 1'b1;
                            nxt_ptr = i[1:0] + 2'h1;
                        end
                    end
                end
            end else if (req[3] && core_req && core_lt) begin
                gnt[3] = 1'b1;
                nxt_ptr = 2'h0;
            end else begin
                // Equal priority or a single requester: round robin P, X, Y, DMA.
                for (i = 3'h0; i < 3'h4; i = i + 3'h1) begin
                    idx = ptr_ff + i[1:0];
                    if (!found && req[idx]) begin
                        found = 1'b1;
                        gnt[idx] = 1'b1;
                        nxt_ptr = idx + 2'h1;
                    end
                end
            end
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ptr_ff <= 2'h0;
        end else if (clk_en) begin
            ptr_ff <= nxt_ptr;
        end
    end

endmodule // psr_bus_arb

/* File: rtl/psr_status_reg.v */
/*
 * Processor status word: three byte slices, stack push on loop and call,
 * APB access and core/DMA external bus arbitration.
 * Assumes core event strobes are one-cycle pulses synchronous to pclk.
 */
// Design decisions made here: register access over APB and the placing of the registers.
// How it works
// - 24-bit word built from three bytes
// - Push whole word on loop or call
// - Reset, exception, loop end, return, trap update modes
// - Status-word destination writes extended mode byte
// - Reset clears extended byte, priority reads 11
// - Loop start, AND, OR, moves update mode
// - Reset sets interrupt masks, clears other mode bits
// - ALU, moves, AND/OR, status writes update flags
// - Parallel move changes only scaling, limit
// - Reset clears all condition flags
// - Reserved bits read zero; software writes zero
// - Core priority field sets external access priority
// - Higher core priority makes DMA wait
// - Lower core priority makes core wait
// - Equal priorities share bus round robin
`timescale 1ns/100ps
`include "psr_map.vh"

module psr_status_reg (
    input wire pclk,
    input wire presetn,
    input wire clk_en,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire loop_init,
    input wire sub_jump,
    input wire mode_restore,
    input wire [23:0] restore_word,
    input wire loop_start,
    input wire [7:0] loop_mode_set,
    input wire word_dest_wr,
    input wire [23:0] word_dest_data,
    input wire mode_and_imm,
    input wire mode_or_imm,
    input wire cc_and_imm,
    input wire cc_or_imm,
    input wire [7:0] imm_data,
    input wire alu_update,
    input wire [7:0] alu_flags,
    input wire parallel_move,
    input wire [7:0] pmove_flags,
    input wire [1:0] dma_pri,
    input wire bus_free,
    input wire [3:0] ext_req,
    output wire [3:0] ext_grant,
    output wire [23:0] status_word,
    output wire [23:0] stack_data,
    output wire stack_push
);

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    reg [1:0] cdp_ff;
    reg [23:0] stack_ff [0:`PSR_STACK_DEPTH-1];
    reg [`PSR_STACK_AW:0] sp_ff;
    reg [23:0] push_data_ff;
    reg push_ff;
    reg [31:0] rdata_ff;
    reg [31:0] nxt_rdata;
    reg slverr_ff;
    reg addr_ok;

    wire [7:0] emr_q;
    wire [7:0] mr_q;
    wire [7:0] ccr_q;
    wire [23:0] word;
    wire apb_wr;
    wire apb_rd;
    wire sw_word_wr;
    wire [3:0] grant_w;
    wire [1:0] ptr_w;

    assign apb_wr = psel && penable && pwrite && clk_en;
    assign apb_rd = psel && penable && !pwrite && clk_en;
    assign sw_word_wr = apb_wr && (paddr == `PSR_ADDR_STATUS);

    // ------------------------------------------------------------------
    // Extended mode byte
    // ------------------------------------------------------------------
    reg emr_wr;
    reg [7:0] emr_d;
    reg [7:0] emr_bits;

    always @* begin
        emr_wr = 1'b0;
        emr_d = emr_q;
        emr_bits = 8'hff;
        if (mode_restore) begin
            emr_wr = 1'b1;
            emr_d = restore_word[23:16];
        end else if (word_dest_wr) begin
            emr_wr = 1'b1;
            emr_d = word_dest_data[23:16];
        end else if (sw_word_wr) begin
            emr_wr = 1'b1;
            emr_d = pwdata[23:16];
        end
    end

    // Reset leaves the priority field at binary 11 and every flag clear.
    psr_byte_reg #(
        .RESET_VAL(`PSR_EMR_RESET),
        .WR_MASK(`PSR_EMR_MASK)
    ) u_emr (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .wr_en(emr_wr),
        .wr_data(emr_d),
        .wr_bits(emr_bits),
        .value(emr_q)
    );

    // ------------------------------------------------------------------
    // Mode byte
    // ------------------------------------------------------------------
    reg mr_wr;
    reg [7:0] mr_d;
    reg [7:0] mr_bits;

    always @* begin
        mr_wr = 1'b1;
        mr_d = mr_q;
        mr_bits = 8'hff;
        if (mode_restore) begin
            mr_d = restore_word[15:8];
        end else if (word_dest_wr) begin
            mr_d = word_dest_data[15:8];
        end else if (sw_word_wr) begin
            mr_d = pwdata[15:8];
        end else if (mode_and_imm) begin
            mr_d = mr_q & imm_data;
        end else if (mode_or_imm) begin
            mr_d = mr_q | imm_data;
        end else if (loop_start) begin
            mr_d = mr_q | loop_mode_set;
        end else begin
            mr_wr = 1'b0;
        end
    end

    psr_byte_reg #(
        .RESET_VAL(`PSR_MR_RESET),
        .WR_MASK(`PSR_MR_MASK)
    ) u_mr (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .wr_en(mr_wr),
        .wr_data(mr_d),
        .wr_bits(mr_bits),
        .value(mr_q)
    );

    // ------------------------------------------------------------------
    // Condition code byte
    // ------------------------------------------------------------------
    reg cc_wr;
    reg [7:0] cc_d;
    reg [7:0] cc_bits;

    always @* begin
        cc_wr = 1'b1;
        cc_d = ccr_q;
        cc_bits = 8'hff;
        if (mode_restore) begin
            cc_d = restore_word[7:0];
        end else if (word_dest_wr) begin
            cc_d = word_dest_data[7:0];
        end else if (sw_word_wr) begin
            cc_d = pwdata[7:0];
        end else if (cc_and_imm) begin
            cc_d = ccr_q & imm_data;
        end else if (cc_or_imm) begin
            cc_d = ccr_q | imm_data;
        end else if (alu_update || parallel_move) begin
            // An ALU result owns all flags, except S and L when a parallel move comes in the same cycle; a lone parallel move only S and L.
            cc_d = alu_update ? alu_flags : pmove_flags;
            cc_bits = alu_update ? 8'hff : `PSR_PMOVE_MASK;
            if (alu_update && parallel_move) begin
                cc_d = (alu_flags & ~`PSR_PMOVE_MASK) | (pmove_flags & `PSR_PMOVE_MASK);
            end
        end else begin
            cc_wr = 1'b0;
        end
    end

    psr_byte_reg #(
        .RESET_VAL(`PSR_CCR_RESET),
        .WR_MASK(`PSR_CCR_MASK)
    ) u_ccr (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .wr_en(cc_wr),
        .wr_data(cc_d),
        .wr_bits(cc_bits),
        .value(ccr_q)
    );

    // Byte layout fixes every flag at its documented position.
    assign word = {emr_q, mr_q, ccr_q};
    assign status_word = word;

    // ------------------------------------------------------------------
    // System stack push
    // ------------------------------------------------------------------
    integer k;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sp_ff <= {(`PSR_STACK_AW+1){1'b0}};
            push_ff <= 1'b0;
            push_data_ff <= 24'h000000;
            for (k = 0; k < `PSR_STACK_DEPTH; k = k + 1) begin
                stack_ff[k] <= 24'h000000;
            end
        end else if (clk_en) begin
            push_ff <= loop_init || sub_jump;
            if (loop_init || sub_jump) begin
                push_data_ff <= word;
                stack_ff[sp_ff[`PSR_STACK_AW-1:0]] <= word;
                if (sp_ff != `PSR_STACK_DEPTH) begin
                    sp_ff <= sp_ff + 1'b1;
                end
            end
        end
    end

    assign stack_push = push_ff;
    assign stack_data = push_data_ff;

    // ------------------------------------------------------------------
    // External bus arbitration
    // ------------------------------------------------------------------
    psr_bus_arb u_arb (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .core_pri(emr_q[`PSR_CP_HI-16:`PSR_CP_LO-16]),
        .dma_pri(dma_pri),
        .cdp_mode(cdp_ff),
        .bus_free(bus_free),
        .req(ext_req),
        .grant(grant_w),
        .rr_ptr(ptr_w)
    );

    assign ext_grant = grant_w;

    // ------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------
    always @* begin
        addr_ok = 1'b1;
        nxt_rdata = 32'h00000000;
        case (paddr)
            `PSR_ADDR_STATUS: nxt_rdata = {8'h00, word};
            `PSR_ADDR_ARB_CTRL: nxt_rdata = {30'h00000000, cdp_ff};
            `PSR_ADDR_ARB_STATUS: nxt_rdata = {24'h000000, grant_w, ptr_w, dma_pri};
            `PSR_ADDR_STACK_TOP: nxt_rdata = {3'h0, sp_ff, push_data_ff};
            default: addr_ok = 1'b0;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cdp_ff <= `PSR_CDP_DYNAMIC;
            rdata_ff <= 32'h00000000;
            slverr_ff <= 1'b0;
        end else if (clk_en) begin
            slverr_ff <= 1'b0;
            if (psel && !penable) begin
                rdata_ff <= nxt_rdata;
                slverr_ff <= !addr_ok;
            end
            if (apb_wr && paddr == `PSR_ADDR_ARB_CTRL) begin
                cdp_ff <= pwdata[1:0];
            end
        end
    end

    assign pready = 1'b1;
    assign prdata = apb_rd ? rdata_ff : 32'h00000000;
    assign pslverr = psel && penable && slverr_ff;

endmodule // psr_status_reg

/* File: tb/psr_status_reg_props.sv */
/*
 * Assertions for the processor status word block.
 * Assumes binding to psr_status_reg and sight of its ports only.
 */
`timescale 1ns/100ps
module psr_status_reg_props (
    input wire pclk,
    input wire presetn,
    input wire clk_en,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire loop_init,
    input wire sub_jump,
    input wire mode_restore,
    input wire [23:0] restore_word,
    input wire [1:0] dma_pri,
    input wire [3:0] ext_req,
    input wire [3:0] ext_grant,
    input wire [23:0] status_word,
    input wire [23:0] stack_data,
    input wire stack_push
);
    // ------------------------------------------------------------------
    // Shadow of the core/DMA priority mode
    // ------------------------------------------------------------------
    reg [1:0] mode_ff;
    wire [1:0] cp = status_word[23:22];
    wire core_hi = mode_ff == 2'h3 || (mode_ff == 2'h0 && cp > dma_pri);
    wire core_lo = mode_ff == 2'h1 || (mode_ff == 2'h0 && cp < dma_pri);
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            mode_ff <= 2'h0;
        else if (clk_en && psel && penable && pwrite && paddr == 12'h004)
            mode_ff <= pwdata[1:0];
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_reset_word: assert property ($rose(presetn) |-> status_word == 24'hc00300)
        else $error("status word reset value wrong");
    a_read_word: assert property (psel && penable && !pwrite && paddr == 12'h000
        |-> prdata == {8'h00, $past(status_word)}) else $error("read data differs from status word");
    a_reserved_zero: assert property (status_word[18] == 1'b0 && status_word[12] == 1'b0)
        else $error("reserved bit set");
    a_push_pulse: assert property ((loop_init || sub_jump) && clk_en
        |=> stack_push && stack_data == $past(status_word)) else $error("push missing");
    a_push_cause: assert property (stack_push |-> $past(loop_init || sub_jump))
        else $error("push without cause");
    a_restore_mode: assert property (mode_restore && clk_en
        |=> status_word[23:8] == ($past(restore_word[23:8]) & 16'hfbef)) else $error("restore wrong");
    a_grant_legal: assert property ($onehot0(ext_grant) && (ext_grant & ~ext_req) == 4'h0)
        else $error("illegal grant");
    a_dma_waits: assert property (core_hi && ext_req[2:0] != 3'h0 |-> !ext_grant[3])
        else $error("dma granted over core");
    a_core_waits: assert property (core_lo && ext_req[3] |-> ext_grant[2:0] == 3'h0)
        else $error("core granted over dma");

    c_push: cover property (stack_push);
    c_restore: cover property (mode_restore && clk_en);
    c_dma_grant: cover property (ext_grant[3] && ext_req[2:0] != 3'h0);
endmodule // psr_status_reg_props

bind psr_status_reg psr_status_reg_props u_props (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .loop_init(loop_init), .sub_jump(sub_jump), .mode_restore(mode_restore), .restore_word(restore_word),
    .dma_pri(dma_pri), .ext_req(ext_req), .ext_grant(ext_grant), .status_word(status_word),
    .stack_data(stack_data), .stack_push(stack_push));

/* File: tb/psr_status_reg_tb.sv */
/*
 * Self-checking bench for the processor status word block.
 * Assumes the design and its map header are compiled beforehand.
 */
`timescale 1ns/100ps
module psr_status_reg_tb;
    logic pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1, bus_free = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err, stack_push;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [23:0] dat = 24'h0, status_word, stack_data;
    logic [10:0] strb = 11'h000;
    logic [1:0] dma_pri = 2'h0;
    logic [3:0] ext_req = 4'h0, ext_grant;
    int error_cnt = 0, cmp_count = 0;

    always #12.5 pclk = ~pclk;

    psr_status_reg DUT (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .loop_init(strb[10]), .sub_jump(strb[9]), .mode_restore(strb[8]),
        .restore_word(dat), .loop_start(strb[7]), .loop_mode_set(dat[7:0]), .word_dest_wr(strb[6]),
        .word_dest_data(dat), .mode_and_imm(strb[5]), .mode_or_imm(strb[4]), .cc_and_imm(strb[3]),
        .cc_or_imm(strb[2]), .imm_data(dat[7:0]), .alu_update(strb[1]), .alu_flags(dat[7:0]),
        .parallel_move(strb[0]), .pmove_flags(dat[7:0]), .dma_pri(dma_pri), .bus_free(bus_free),
        .ext_req(ext_req), .ext_grant(ext_grant), .status_word(status_word), .stack_data(stack_data),
        .stack_push(stack_push));

    task chk(input string n, input [31:0] e, input [31:0] g);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value %s: expected %h, seen %h", n, e, g);
        end
    endtask

    task cs(input [23:0] e);
        chk("status_word", {8'h00, e}, {8'h00, status_word});
    endtask

    task apb(input w, input [11:0] a, input [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // One-cycle pulse on core event k, with dat on all its data inputs.
    task ev(input [3:0] k, input [23:0] d);
        @(posedge pclk);
        dat <= d;
        strb <= 11'h001 << k;
        @(posedge pclk);
        strb <= 11'h000;
        @(negedge pclk);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task t_reset;
        cs(24'hc00300);
        apb(1'b0, 12'h000, 32'h0);
        chk("read word", 32'h00c00300, rd);
        chk("slverr ok", 32'h0, {31'h0, err});
        apb(1'b0, 12'h010, 32'h0);
        chk("slverr bad", 32'h1, {31'h0, err});
    endtask

    task t_reserved;
        apb(1'b1, 12'h000, 32'h00ffffff);
        apb(1'b0, 12'h000, 32'h0);
        chk("reserved", 32'h00fbefff, rd);
    endtask

    task t_dest_imm;
        ev(4'd6, 24'h123456);
        cs(24'h122456);
        ev(4'd4, 24'h000003);
        cs(24'h122756);
        ev(4'd5, 24'h00000f);
        cs(24'h120756);
        ev(4'd2, 24'h000081);
        cs(24'h1207d7);
        ev(4'd3, 24'h00000f);
        cs(24'h120707);
    endtask

    task t_flags;
        ev(4'd1, 24'h00003c);
        cs(24'h12073c);
        ev(4'd0, 24'h0000ff);
        cs(24'h1207fc);
    endtask

    task t_loop_push;
        ev(4'd7, 24'h000080);
        cs(24'h1287fc);
        ev(4'd9, 24'h000000);
        chk("push", 32'h1, {31'h0, stack_push});
        chk("stack", 32'h001287fc, {8'h00, stack_data});
        ev(4'd10, 24'h000000);
        chk("push", 32'h1, {31'h0, stack_push});
        apb(1'b0, 12'h00c, 32'h0);
        chk("stack top", 32'h021287fc, rd);
    endtask

    task t_restore;
        ev(4'd8, 24'hffffff);
        chk("restore", 32'h0000fbef, {16'h0, status_word[23:8]});
        @(posedge pclk);
        clk_en <= 1'b0;
        ev(4'd6, 24'h000000);
        cs(24'hfbefff);
        @(posedge pclk);
        clk_en <= 1'b1;
    endtask

    task t_arb;
        apb(1'b1, 12'h000, 32'h00800300);
        @(posedge pclk);
        dma_pri <= 2'h2;
        ext_req <= 4'hf;
        for (int i = 0; i < 5; i++) begin
            @(negedge pclk);
            chk("rr grant", 32'h1 << (i % 4), {28'h0, ext_grant});
        end
        @(posedge pclk);
        dma_pri <= 2'h1;
        @(negedge pclk);
        chk("dma wait", 32'h0, {31'h0, ext_grant[3]});
        @(posedge pclk);
        dma_pri <= 2'h3;
        @(negedge pclk);
        chk("core wait", 32'h8, {28'h0, ext_grant});
        @(posedge pclk);
        ext_req <= 4'h0;
        apb(1'b1, 12'h004, 32'h1);
        apb(1'b0, 12'h004, 32'h0);
        chk("prio mode", 32'h1, rd);
        @(posedge pclk);
        dma_pri <= 2'h0;
        ext_req <= 4'hf;
        @(negedge pclk);
        chk("static grant", 32'h8, {28'h0, ext_grant});
        @(posedge pclk);
        ext_req <= 4'h0;
    endtask

    task tally_and_finish;
        if (error_cnt == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        t_reset;
        t_reserved;
        t_dest_imm;
        t_flags;
        t_loop_push;
        t_restore;
        t_arb;
        tally_and_finish;
    end

    initial begin
        #200000;
        error_cnt++;
        tally_and_finish;
    end
endmodule // psr_status_reg_tb
